//--- hw/fifo_ctl_pkg.sv
// package: register map, field layout, reset values and types for the fifo control block
package fifo_ctl_pkg;
	localparam int RX_AW = 10; // rx address width parameter (fixed)
	localparam int TX_AW = 10; // tx address width parameter (fixed)
	localparam int RXW = RX_AW + 1; // rx watermark field width
	localparam int TXW = TX_AW + 1; // tx watermark field width
	localparam int TXA = TX_AW + 2; // tx ram write address field width
	localparam int VECW = 18; // statistics vector width

	// byte addresses
	localparam logic [7:0] OFS_RX_WM = 8'h50;
	localparam logic [7:0] OFS_TX_WM = 8'h54;
	localparam logic [7:0] OFS_MATCH = 8'h58;
	localparam logic [7:0] OFS_MODE = 8'h5C;
	localparam logic [7:0] OFS_TRAM = 8'h60;
	localparam logic [7:0] OFS_TRAM_DAT = 8'h64;

	// field positions
	localparam int POS_HI = 16;
	localparam int POS_HDPLX = 22;
	localparam int POS_FULL = 21;
	localparam int POS_FULLCLR = 20;
	localparam int POS_BYTMODE = 19;
	localparam int POS_SHORT = 18;
	localparam int POS_REQ = 31;
	localparam int POS_ACK = 30;
	localparam int POS_CTL = 16;

	// statistics vector bit positions
	localparam int VB_UC_MISS = 17;
	localparam int VB_TRUNC = 16;
	localparam int VB_LONG = 15;
	localparam int VB_VLAN = 14;
	localparam int VB_BADOP = 13;
	localparam int VB_PAUSE = 12;
	localparam int VB_CTRL = 11;
	localparam int VB_DRIBBLE = 10;
	localparam int VB_BCAST = 9;
	localparam int VB_MCAST = 8;
	localparam int VB_OK = 7;
	localparam int VB_LEN_RANGE = 6;
	localparam int VB_LEN_ERR = 5;
	localparam int VB_CRC = 4;
	localparam int VB_CODE = 3;
	localparam int VB_FALSE_CAR = 2;
	localparam int VB_SHORT_DV = 1;
	localparam int VB_IFG_DROP = 0;

	// reset values and fixed codes and lengths
	localparam logic [VECW-1:0] RST_MATCH = 18'h00008;
	localparam logic [VECW-1:0] RST_DC = 18'h3FFF7;
	localparam logic RST_BYTMODE = 1'b1;
	localparam logic [7:0] FALSE_CAR_CODE = 8'h0E;
	localparam logic [15:0] STD_MAX_LEN = 16'h05EE; // 1518 bytes
	localparam logic [15:0] MIN_LEN = 16'h0040; // 64 bytes

	// end-of-frame report from the receive mac
	typedef struct packed {
		logic valid;
		logic [15:0] length;
		logic [VECW-1:0] vec;
	} rx_stat_t;

	// one transmit ram debug write
	typedef struct packed {
		logic ptr_load;
		logic [TXA-1:0] addr;
		logic [39:0] data;
	} tram_wr_t;

	typedef enum logic [1:0] {
		TW_IDLE = 2'b00,
		TW_ACK = 2'b01
	} tw_state_t;
endpackage

//--- hw/mac_fifo_ctl.sv
// mac fifo control: thresholds, flow control, frame drop filter, register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module mac_fifo_ctl
	import fifo_ctl_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	// axi4-lite slave
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	// fifo occupancy, in words, and transmit write pointer
	input wire logic [RXW:0] rx_level, // receive fifo word count
	input wire logic [TXW:0] tx_level, // transmit fifo word count
	input wire logic [TX_AW:0] tx_wptr, // transmit module write pointer
	// receive mac side
	input wire logic rx_er, // receive error pin
	input wire logic rx_dv, // receive data valid pin
	input wire logic [7:0] rx_d, // receive data pins
	input wire rx_stat_t rx_stat, // end-of-frame statistics
	input wire logic [15:0] max_frame_len, // configured maximum frame length
	output logic rx_drop, // one-cycle drop of reported frame
	output logic [VECW-1:0] rx_vec, // completed statistics vector
	// flow control and transfer mode
	input wire logic pause_ack, // pause frame request taken by mac
	output logic xoff_req, // request xoff pause frame
	output logic xon_req, // request xon pause frame
	output logic hd_backpressure, // half-duplex backpressure
	output logic dma_stop, // dma stop fetching
	output logic tx_start, // mac may start transmission
	output logic byte_mode, // one byte per qualified clock
	// transmit ram debug write port
	output tram_wr_t tram_wr, // write payload
	output logic tram_wr_valid, // one-cycle write strobe
	output logic [RXW-1:0] rx_capacity_dbg // unused width marker
);
	// configuration registers
	logic [RXW-1:0] rx_hwm_r, rx_lwm_r;
	logic [TXW-1:0] tx_hwm_r, tx_cut_r;
	logic [VECW-1:0] match_r, dc_r;
	logic hdplx_r, fullclr_r, bytmode_r, short_r;
	logic req_r, ack_r, full_r, xoff_sent_r;
	logic [TXA-1:0] taddr_r;
	logic [7:0] tctl_r;
	logic [31:0] tdat_r;
	logic fc_seen_r;
	tw_state_t tw_r;

	// axi slave state
	logic aw_r, w_r;
	logic [7:0] awa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic wr_go, rd_go;

	assign s_axi_awready = !aw_r && !s_axi_bvalid;
	assign s_axi_wready = !w_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_r && w_r && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rx_capacity_dbg = '1;

	// write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r <= 1'b1;
				awa_r <= s_axi_awaddr[7:0];
			end else if (wr_go) begin
				aw_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_r <= 1'b0;
			end
		end
	end

	// write response, slverr on unmapped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awa_r inside {OFS_RX_WM, OFS_TX_WM, OFS_MATCH, OFS_MODE,
					OFS_TRAM, OFS_TRAM_DAT}) ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration writes, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_hwm_r <= '1;
			rx_lwm_r <= '1;
			tx_hwm_r <= '1;
			tx_cut_r <= '1;
			match_r <= RST_MATCH;
			dc_r <= RST_DC;
			hdplx_r <= 1'b0;
			fullclr_r <= 1'b0;
			bytmode_r <= RST_BYTMODE;
			short_r <= 1'b0;
			req_r <= 1'b0;
			tctl_r <= 8'h00;
			taddr_r <= '0;
			tdat_r <= 32'h0000_0000;
		end else if (ce && wr_go) begin
			case (awa_r)
				OFS_RX_WM: begin
					if (ws_r[0]) rx_lwm_r[7:0] <= wd_r[7:0];
					if (ws_r[1]) rx_lwm_r[RXW-1:8] <= wd_r[RXW-1:8];
					if (ws_r[2]) rx_hwm_r[7:0] <= wd_r[23:16];
					if (ws_r[3]) rx_hwm_r[RXW-1:8] <= wd_r[POS_HI+RXW-1:24];
				end
				OFS_TX_WM: begin
					if (ws_r[0]) tx_cut_r[7:0] <= wd_r[7:0];
					if (ws_r[1]) tx_cut_r[TXW-1:8] <= wd_r[TXW-1:8];
					if (ws_r[2]) tx_hwm_r[7:0] <= wd_r[23:16];
					if (ws_r[3]) tx_hwm_r[TXW-1:8] <= wd_r[POS_HI+TXW-1:24];
				end
				OFS_MATCH: begin
					if (ws_r[0]) match_r[7:0] <= wd_r[7:0];
					if (ws_r[1]) match_r[15:8] <= wd_r[15:8];
					if (ws_r[2]) match_r[17:16] <= wd_r[17:16];
				end
				OFS_MODE: begin
					if (ws_r[0]) dc_r[7:0] <= wd_r[7:0];
					if (ws_r[1]) dc_r[15:8] <= wd_r[15:8];
					if (ws_r[2]) begin
						dc_r[17:16] <= wd_r[17:16];
						short_r <= wd_r[POS_SHORT];
						bytmode_r <= wd_r[POS_BYTMODE];
						fullclr_r <= wd_r[POS_FULLCLR];
						hdplx_r <= wd_r[POS_HDPLX];
					end
				end
				OFS_TRAM: begin
					if (ws_r[0]) taddr_r[7:0] <= wd_r[7:0];
					if (ws_r[1]) taddr_r[TXA-1:8] <= wd_r[TXA-1:8];
					if (ws_r[2]) tctl_r <= wd_r[POS_CTL+7:POS_CTL];
					if (ws_r[3]) req_r <= wd_r[POS_REQ];
				end
				OFS_TRAM_DAT: begin
					if (ws_r[0]) tdat_r[7:0] <= wd_r[7:0];
					if (ws_r[1]) tdat_r[15:8] <= wd_r[15:8];
					if (ws_r[2]) tdat_r[23:16] <= wd_r[23:16];
					if (ws_r[3]) tdat_r[31:24] <= wd_r[31:24];
				end
				default: begin
				end
			endcase
		end
	end

	// read data mux
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (ce) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr[7:0])
					OFS_RX_WM: s_axi_rdata <= 32'({rx_hwm_r, 16'h0000}) | 32'(rx_lwm_r);
					OFS_TX_WM: s_axi_rdata <= 32'({tx_hwm_r, 16'h0000}) | 32'(tx_cut_r);
					OFS_MATCH: s_axi_rdata <= 32'(match_r);
					OFS_MODE: s_axi_rdata <= {9'h000, hdplx_r, full_r, fullclr_r,
						bytmode_r, short_r, dc_r};
					OFS_TRAM: s_axi_rdata <= {req_r, ack_r, 6'h00, tctl_r, 4'h0,
						taddr_r[TXA-1], tx_wptr};
					OFS_TRAM_DAT: s_axi_rdata <= tdat_r;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// transmit ram write handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tw_r <= TW_IDLE;
			ack_r <= 1'b0;
			tram_wr_valid <= 1'b0;
			tram_wr <= '0;
		end else if (ce) begin
			tram_wr_valid <= 1'b0;
			case (tw_r)
				TW_IDLE: begin
					if (req_r) begin
						tram_wr.ptr_load <= taddr_r[TXA-1];
						tram_wr.addr <= taddr_r;
						// valid-byte code carried in bits 33:32
						tram_wr.data <= {tctl_r, tdat_r};
						tram_wr_valid <= 1'b1;
						ack_r <= 1'b1;
						tw_r <= TW_ACK;
					end
				end
				TW_ACK: begin
					if (!req_r) begin
						ack_r <= 1'b0;
						tw_r <= TW_IDLE;
					end
				end
				default: tw_r <= TW_IDLE;
			endcase
		end
	end

	// sticky full flag, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_r <= 1'b0;
		end else if (ce) begin
			if (rx_level >= {1'b0, {RXW{1'b1}}})
				full_r <= 1'b1;
			else if (fullclr_r)
				full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xoff_sent_r <= 1'b0;
			xoff_req <= 1'b0;
			xon_req <= 1'b0;
		end else if (ce) begin
			if (pause_ack) begin
				xoff_req <= 1'b0;
				xon_req <= 1'b0;
			end
			// pause frames only in full duplex
			if (!hdplx_r && !xoff_sent_r && rx_level >= {1'b0, rx_hwm_r}) begin
				xoff_sent_r <= 1'b1;
				xoff_req <= 1'b1;
			end else if (!hdplx_r && xoff_sent_r && rx_level <= {1'b0, rx_lwm_r}) begin
				xoff_sent_r <= 1'b0;
				xon_req <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hd_backpressure <= 1'b0;
			dma_stop <= 1'b0;
			tx_start <= 1'b0;
		end else if (ce) begin
			hd_backpressure <= hdplx_r && (rx_level >= {1'b0, rx_hwm_r});
			dma_stop <= tx_level >= {1'b0, tx_hwm_r};
			tx_start <= tx_level >= {1'b0, tx_cut_r};
		end
	end

	// false carrier noted for next vector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fc_seen_r <= 1'b0;
		end else if (ce) begin
			if (rx_er && !rx_dv && rx_d == FALSE_CAR_CODE)
				fc_seen_r <= 1'b1;
			else if (rx_stat.valid)
				fc_seen_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_drop <= 1'b0;
			rx_vec <= '0;
		end else if (ce) begin
			rx_drop <= 1'b0;
			if (rx_stat.valid) begin
				rx_vec <= rx_stat.vec;
				rx_vec[VB_FALSE_CAR] <= rx_stat.vec[VB_FALSE_CAR] | fc_seen_r;
				rx_vec[VB_LEN_RANGE] <= (rx_stat.length > STD_MAX_LEN)
					&& (rx_stat.length < max_frame_len);
				rx_drop <= (((rx_stat.vec ^ match_r) & ~dc_r) == '0
					&& 1'b1) || (short_r && rx_stat.length < MIN_LEN);
			end
		end
	end

	assign byte_mode = bytmode_r;
endmodule

//--- dv/mac_fifo_ctl_assertions.sv
// checker: port-level assertions for the fifo control block
`timescale 1ns/1ps
module mac_fifo_ctl_chk
	import fifo_ctl_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic ce, // enable
	input wire logic s_axi_wvalid, // wdata valid
	input wire logic [TXW:0] tx_level, // tx words
	input wire logic rx_er, // rx error
	input wire logic rx_dv, // rx valid
	input wire logic [7:0] rx_d, // rx data
	input wire rx_stat_t rx_stat, // frame report
	input wire logic [15:0] max_frame_len, // max length
	input wire logic rx_drop, // drop
	input wire logic [VECW-1:0] rx_vec, // vector
	input wire logic xoff_req, // xoff
	input wire logic xon_req, // xon
	input wire logic dma_stop, // dma stop
	input wire logic tx_start, // tx start
	input wire logic byte_mode, // byte mode
	input wire logic tram_wr_valid // ram write
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// tx level and config held still
	sequence quiet_s;
		$stable(tx_level) && !s_axi_wvalid && ce;
	endsequence

	drop_cause_a: assert property (rx_drop |-> $past(rx_stat.valid))
		else $error("drop without a frame report");
	vec_upper_a: assert property (rx_stat.valid && ce |=>
		rx_vec[17:7] == $past(rx_stat.vec[17:7])) else $error("upper vector bits wrong");
	vec_lower_a: assert property (rx_stat.valid && ce |=>
		rx_vec[5:3] == $past(rx_stat.vec[5:3]) && rx_vec[1:0] == $past(rx_stat.vec[1:0]))
		else $error("lower vector bits wrong");
	len_range_a: assert property (rx_stat.valid && ce |=> rx_vec[VB_LEN_RANGE] ==
		($past(rx_stat.length) > STD_MAX_LEN && $past(rx_stat.length) < $past(max_frame_len)))
		else $error("length range bit wrong");
	false_car_a: assert property (rx_er && !rx_dv && rx_d == FALSE_CAR_CODE && ce
		##1 rx_stat.valid && ce |=> rx_vec[VB_FALSE_CAR]) else $error("false carrier lost");
	pause_excl_a: assert property (!(xoff_req && xon_req))
		else $error("xoff and xon both pending");
	tx_quiet_a: assert property (quiet_s [*5] |->
		$stable(dma_stop) && $stable(tx_start)) else $error("tx flags moved while idle");
	reset_out_a: assert property ($rose(aresetn) |-> byte_mode && !dma_stop &&
		!tx_start && !xoff_req && !xon_req && !rx_drop) else $error("bad output after reset");
	tram_pulse_a: assert property (tram_wr_valid |=> !tram_wr_valid)
		else $error("ram write strobe too long");

	cover property (rx_drop);
	cover property (tram_wr_valid);
	cover property (xon_req);
endmodule

bind mac_fifo_ctl mac_fifo_ctl_chk u_chk (.aclk, .aresetn, .ce, .s_axi_wvalid, .tx_level,
	.rx_er, .rx_dv, .rx_d, .rx_stat, .max_frame_len, .rx_drop, .rx_vec, .xoff_req, .xon_req,
	.dma_stop, .tx_start, .byte_mode, .tram_wr_valid);

//--- dv/pause_peer.sv
// partner: mac side that acknowledges pause frame requests
`timescale 1ns/1ps
module pause_peer (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic slow, // long answer delay
	input wire logic xoff_req, // xoff request
	input wire logic xon_req, // xon request
	output logic pause_ack // one-cycle acknowledge
);
	logic [3:0] wait_r;

	// count while a request waits, then pulse the acknowledge once
	always_ff @(posedge aclk) begin
		if (!aresetn || pause_ack || !(xoff_req || xon_req)) begin
			wait_r <= 4'h0;
			pause_ack <= 1'h0;
		end else if (wait_r >= (slow ? 4'h8 : 4'h1)) begin
			pause_ack <= 1'h1;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule

//--- dv/testbench.sv
// testbench: register, threshold, filter and debug-write checks
`timescale 1ns/1ps
module testbench
	import fifo_ctl_pkg::*;
;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
	logic [RXW:0] rx_level;
	logic [TXW:0] tx_level, lvl;
	logic [TX_AW:0] tx_wptr;
	logic rx_er, rx_dv, pause_ack, xoff_req, xon_req, hd_backpressure, dma_stop, tx_start;
	logic byte_mode, rx_drop, tram_wr_valid, slow;
	logic [7:0] rx_d, ctl;
	rx_stat_t rx_stat;
	logic [15:0] max_frame_len, n;
	logic [VECW-1:0] rx_vec, mt, mk, v;
	tram_wr_t tram_wr, tw_c;
	logic [10:0] h, c;
	logic [RXW-1:0] cap_dbg;
	logic [11:0] a;
	int error_cnt, cmp_count, tw_n;

	mac_fifo_ctl DUT (.*, .rx_capacity_dbg(cap_dbg));
	pause_peer peer (.aclk, .aresetn, .slow, .xoff_req, .xon_req, .pause_ack);

	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end

	// catch ram debug writes
	always @(posedge aclk) begin
		if (tram_wr_valid === 1'h1) begin
			tw_n++;
			tw_c = tram_wr;
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t ns: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [31:0] ad);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic send_stat(input logic [15:0] nn, input logic [VECW-1:0] vv);
		rx_stat <= {1'h1, nn, vv};
		@(posedge aclk);
		rx_stat.valid <= 1'h0;
		@(posedge aclk);
	endtask

	// vector as reported: range bit rebuilt, false carrier merged
	function automatic logic [VECW-1:0] exp_vec(input logic [VECW-1:0] vv,
		input logic [15:0] nn, input logic fc);
		logic [VECW-1:0] e;
		e = vv;
		e[VB_LEN_RANGE] = nn > STD_MAX_LEN && nn < max_frame_len;
		e[VB_FALSE_CAR] = vv[VB_FALSE_CAR] | fc;
		return e;
	endfunction

	// filter match, or any short frame (short drop enable not checked)
	function automatic logic exp_drop(input logic [VECW-1:0] vv, input logic [15:0] nn,
		input logic [VECW-1:0] m, input logic [VECW-1:0] k);
		return ((vv ^ m) & ~k) == '0 || nn < MIN_LEN;
	endfunction

	task automatic endt(input string s);
		$display("test %0s done", s);
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, rx_level, tx_level, tx_wptr} = '0;
		{rx_er, rx_dv, rx_d, rx_stat} = '0;
		ce = 1'h1;
		s_axi_wstrb = 4'hF;
		max_frame_len = 16'h07D0;
		slow = 1'h1;
		error_cnt = 0;
		cmp_count = 0;
		tw_n = 0;
		void'($urandom(32'hF0CE7223));
		tick(10);
		aresetn <= 1'h1;
		rd(OFS_RX_WM);
		chk(rd_d, 32'h07FF07FF);
		rd(OFS_TX_WM);
		chk(rd_d, 32'h07FF07FF);
		rd(OFS_MATCH);
		chk(rd_d, 32'h00000008);
		rd(OFS_MODE);
		chk(rd_d, 32'h000BFFF7);
		rd(32'h70);
		chk(rd_r, 2'h2);
		chk(cap_dbg, {RXW{1'b1}});
		endt("reset");
		// levels idle while config is written
		wr(OFS_RX_WM, 32'h00140005);
		rx_level <= 12'h013;
		tick(3);
		chk(xoff_req, 0);
		rx_level <= 12'h014;
		tick(3);
		chk(xoff_req, 1);
		rx_level <= 12'h00A;
		tick(12);
		chk(xon_req, 0);
		rx_level <= 12'h005;
		tick(3);
		chk(xon_req, 1);
		slow <= 1'h0;
		tick(4);
		chk(xon_req, 0);
		endt("pause");
		wr(OFS_MODE, 32'h0043FFF7);
		rx_level <= 12'h014;
		tick(3);
		chk(hd_backpressure, 1);
		chk(xoff_req, 0);
		chk(byte_mode, 0);
		rx_level <= '0;
		wr(OFS_MODE, 32'h000BFFF7);
		chk(hd_backpressure, 0);
		endt("half duplex");
		h = $urandom_range(2047, 1);
		c = $urandom_range(2047, 1);
		wr(OFS_TX_WM, {5'h0, h, 5'h0, c});
		for (int i = 0; i < 24; i++) begin
			lvl = (i == 0) ? h : (i == 1) ? h - 11'h1 : (i == 2) ? c : $urandom_range(2047, 0);
			tx_level <= lvl;
			tick(3);
			chk(dma_stop, lvl >= h);
			chk(tx_start, lvl >= c);
		end
		// clock enable low freezes the dma_stop compare output
		ce <= 1'h0;
		tx_level <= (lvl >= h) ? 12'h000 : 12'hFFF;
		tick(3);
		chk(dma_stop, lvl >= h);
		ce <= 1'h1;
		tick(3);
		chk(dma_stop, lvl < h);
		endt("tx thresholds");
		mt = $urandom;
		mk = $urandom | 18'h00044;
		wr(OFS_MATCH, {14'h0, mt});
		wr(OFS_MODE, {14'h3, mk});
		for (int i = 0; i < 40; i++) begin
			v = (i < 3) ? mt : $urandom;
			n = (i == 3) ? MIN_LEN : (i == 4) ? 16'h003F : (i == 5) ? 16'h05EF :
				$urandom_range(2100, 40);
			send_stat(n, v);
			chk(rx_drop, exp_drop(v, n, mt, mk));
			chk(rx_vec, exp_vec(v, n, 1'h0));
		end
		endt("filter");
		for (int j = 0; j < 2; j++) begin
			rx_er <= 1'h1;
			rx_d <= j ? 8'h0F : FALSE_CAR_CODE;
			tick(1);
			rx_er <= 1'h0;
			send_stat(16'h0100, '0);
			chk(rx_vec[VB_FALSE_CAR], j == 0);
		end
		endt("false carrier");
		// fifo levels idle before ram access
		tx_level <= '0;
		tx_wptr <= $urandom;
		d = $urandom;
		ctl = $urandom;
		a = $urandom_range(1023, 0);
		wr(OFS_TRAM_DAT, d);
		wr(OFS_TRAM, {1'h1, 7'h0, ctl, 4'h0, a});
		tick(4);
		chk(tw_n, 1);
		chk(tw_c.data, {ctl, d});
		chk(tw_c.addr, a);
		chk(tw_c.ptr_load, 0);
		wr(OFS_TRAM, {1'h1, 7'h0, ctl, 4'h0, a});
		rd(OFS_TRAM);
		chk(rd_d[POS_ACK], 1);
		chk(rd_d[TX_AW:0], tx_wptr);
		chk(tw_n, 1);
		wr(OFS_TRAM, 32'h40000000);
		tick(2);
		rd(OFS_TRAM);
		chk(rd_d[POS_ACK], 0);
		a = 12'h800 | $urandom_range(2047, 0);
		wr(OFS_TRAM, {1'h1, 7'h0, ctl, 4'h0, a});
		tick(4);
		chk(tw_n, 2);
		chk(tw_c.ptr_load, 1);
		wr(OFS_TRAM, 32'h0);
		endt("ram write");
		rx_level <= 12'h7FE;
		tick(3);
		rd(OFS_MODE);
		chk(rd_d[POS_FULL], 0);
		rx_level <= 12'h7FF;
		tick(3);
		rd(OFS_MODE);
		chk(rd_d[POS_FULL], 1);
		rx_level <= '0;
		wr(OFS_MODE, 32'h001BFFF7);
		rd(OFS_MODE);
		chk(rd_d[POS_FULL], 0);
		wr(OFS_MODE, 32'h000BFFF7);
		endt("full flag");
		give_verdict();
	end
endmodule
